/* File: vfd_core.sv */
module vfd_core (
	input wire logic clk_sys_i,
	input wire logic reset_n_i,
	output logic fetch_req_o,
	output logic [31:0] fetch_addr_o,
	input wire logic fetch_valid_i,
	input wire logic [255:0] fetch_data_i,
	output logic [7:0] issue_valid_o,
	output logic [255:0] issue_word_o,
	output logic group_drop_o,
	output logic cross_stall_o,
	output logic [1:0] dmem_req_o,
	output logic [1:0] dmem_we_o,
	output logic [3:0] dmem_size_o,
	output logic [63:0] dmem_addr_o,
	output logic [127:0] dmem_wdata_o,
	input wire logic [127:0] dmem_rdata_i
);
	vfd_pkg::vfd_state_t state_reg;
	logic [31:0] pc_reg;
	logic [31:0] buf_reg [16];
	logic [4:0] ptr_reg;
	logic stall_reg;
	logic [31:0] rf_reg [2][32];
	logic [31:0] wlast_reg [2];
	logic [31:0] wl_next [2];
	logic [1:0] ldwb_reg;
	logic [7:0] ldm_reg [2];
	logic [7:0] wbm_reg [2];
	logic [63:0] ldd [2];
	logic [3:0] grp_len;
	logic grp_span, grp_dup, cross_hz, br_take, go, hold, issue;
	logic [31:0] br_tgt;
	logic [7:0] iv_next, wlo, whi, wside;
	logic [31:0] iw_next [8];
	logic [4:0] wdst [8];
	logic [31:0] rlo [8];
	logic [31:0] rhi [8];
	logic [1:0] mreq, mwe;
	logic [31:0] maddr [2];
	logic [63:0] mwdata [2];
	logic [7:0] mmeta [2];

	function automatic vfd_pkg::vfd_ins_t dec(input logic [31:0] w);
		vfd_pkg::vfd_ins_t d;
		d.creg = w[vfd_pkg::F_CREG+:3];
		d.z = w[vfd_pkg::F_Z];
		d.dst = w[vfd_pkg::F_DST+:5];
		d.src2 = w[vfd_pkg::F_SRC2+:5];
		d.src1 = w[vfd_pkg::F_SRC1+:5];
		d.x = w[vfd_pkg::F_X];
		d.lng = w[vfd_pkg::F_LONG];
		d.st = w[vfd_pkg::F_ST];
		d.sz = w[vfd_pkg::F_SZ+:2];
		d.circ = w[vfd_pkg::F_CIRC];
		d.nal = w[vfd_pkg::F_NAL];
		d.op = w[vfd_pkg::F_OP+:4];
		d.unit = w[vfd_pkg::F_UNIT+:2];
		d.side = w[vfd_pkg::F_SIDE];
		d.off15 = {w[vfd_pkg::F_SRC1+:10], w[vfd_pkg::F_X], w[vfd_pkg::F_OP+:4]};
		return d;
	endfunction

	function automatic logic cond_ok(input vfd_pkg::vfd_ins_t d);
		logic c;
		c = 1'b1;
		if (d.creg != 3'h0 && d.creg <= vfd_pkg::CREG_LAST) begin
			if (d.creg < vfd_pkg::CREG_B_BASE) begin
				c = rf_reg[0][5'(d.creg)] != 32'h0; // RULE_18
			end else begin
				c = rf_reg[1][5'(d.creg - vfd_pkg::CREG_B_BASE)] != 32'h0;
			end
			c = c ^ d.z;
		end
		return c;
	endfunction

	function automatic logic [31:0] alu(input logic [3:0] op, input logic [31:0] a, input logic [31:0] b);
		logic [31:0] r;
		r = a;
		case (op) // RULE_21
			vfd_pkg::OP_ADD: r = a + b;
			vfd_pkg::OP_SUB: r = a - b;
			vfd_pkg::OP_ADD2: for (int i = 0; i < 2; i++) r[16*i+:16] = a[16*i+:16] + b[16*i+:16];
			vfd_pkg::OP_SUB2: for (int i = 0; i < 2; i++) r[16*i+:16] = a[16*i+:16] - b[16*i+:16];
			vfd_pkg::OP_ADD4: for (int i = 0; i < 4; i++) r[8*i+:8] = a[8*i+:8] + b[8*i+:8];
			vfd_pkg::OP_SUB4: for (int i = 0; i < 4; i++) r[8*i+:8] = a[8*i+:8] - b[8*i+:8];
			vfd_pkg::OP_AND: r = a & b;
			vfd_pkg::OP_OR: r = a | b;
			vfd_pkg::OP_XOR: r = a ^ b;
			vfd_pkg::OP_SHL: r = a << b[4:0];
			vfd_pkg::OP_SHR: r = a >> b[4:0];
			default: r = a;
		endcase
		return r;
	endfunction

	function automatic logic [7:0] gf_mul(input logic [7:0] x, input logic [7:0] y);
		logic [7:0] p, t;
		p = 8'h00;
		t = x;
		for (int i = 0; i < 8; i++) begin
			if (y[i]) p = p ^ t;
			t = t[7] ? ((t << 1) ^ vfd_pkg::GF_POLY) : (t << 1);
		end
		return p;
	endfunction

	function automatic logic [63:0] mul(input logic [3:0] op, input logic [31:0] a, input logic [31:0] b);
		logic [63:0] r;
		logic signed [31:0] p0, p1;
		logic signed [47:0] pw;
		logic [15:0] u [4];
		r = 64'h0;
		p0 = $signed(a[15:0]) * $signed(b[15:0]);
		p1 = $signed(a[31:16]) * $signed(b[31:16]);
		pw = $signed(a[15:0]) * $signed(b);
		for (int i = 0; i < 4; i++) u[i] = {8'h00, a[8*i+:8]} * {8'h00, b[8*i+:8]};
		case (op) // RULE_19 RULE_20
			vfd_pkg::OP_MPY2: r = {p1, p0};
			vfd_pkg::OP_MPYU4: r = {u[3], u[2], u[1], u[0]};
			vfd_pkg::OP_MPYHL: r = {{16{pw[47]}}, pw};
			vfd_pkg::OP_DOTP2: r[31:0] = p0 + p1;
			vfd_pkg::OP_DOTPN2: r[31:0] = p1 - p0;
			vfd_pkg::OP_DOTPU4: r[31:0] = {16'h0, u[0]} + {16'h0, u[1]} + {16'h0, u[2]} + {16'h0, u[3]};
			vfd_pkg::OP_BITC4: for (int i = 0; i < 4; i++) r[8*i+:8] = 8'($countones(a[8*i+:8]));
			vfd_pkg::OP_ROTL: r[31:0] = 32'({a, a} >> (6'h20 - {1'b0, b[4:0]}));
			vfd_pkg::OP_GMPY4: for (int i = 0; i < 4; i++) r[8*i+:8] = gf_mul(a[8*i+:8], b[8*i+:8]);
			vfd_pkg::OP_SSHVL: r[31:0] = b[31] ? ((-b) > 32'd31 ? 32'h0 : a >> 5'(-b)) : (b > 32'd31 ? 32'h0 : a << b[4:0]);
			default: r = 64'h0;
		endcase
		return r;
	endfunction

	function automatic logic [31:0] agen(input vfd_pkg::vfd_ins_t d, input logic [31:0] base);
		logic [31:0] off, s;
		off = d.lng ? {17'h0, d.off15} : {27'h0, d.src2}; // RULE_17
		off = off << d.sz;
		s = base + off;
		if (!d.lng && d.circ) s = {base[31:vfd_pkg::CIRC_BITS], s[vfd_pkg::CIRC_BITS-1:0]};
		if (d.lng || !d.nal || d.sz < vfd_pkg::SZ_WORD) s = s & ~((32'h1 << d.sz) - 32'h1); // RULE_16
		return s;
	endfunction

	function automatic logic [63:0] ld_ext(input logic [1:0] sz, input logic [63:0] v);
		case (sz) // RULE_15
			vfd_pkg::SZ_BYTE: return {{56{v[7]}}, v[7:0]};
			vfd_pkg::SZ_HALF: return {{48{v[15]}}, v[15:0]};
			vfd_pkg::SZ_WORD: return {32'h0, v[31:0]};
			default: return v;
		endcase
	endfunction

	// Group boundary scan
	always_comb begin
		logic [4:0] idx;
		logic done;
		idx = 5'h0;
		done = ptr_reg == vfd_pkg::PTR_EMPTY;
		grp_len = 4'h0;
		grp_span = 1'b0;
		for (int k = 0; k < 8; k++) begin // RULE_04 RULE_06
			idx = ptr_reg + 5'(k);
			if (!done) begin
				if (idx > 5'h0f) begin
					grp_span = 1'b1; // RULE_05
					done = 1'b1;
				end else begin
					grp_len = grp_len + 4'h1;
					done = !buf_reg[idx[3:0]][0]; // RULE_02 RULE_03
				end
			end
		end
	end

	// Slot decode and execute
	always_comb begin
		vfd_pkg::vfd_ins_t d;
		logic [4:0] idx;
		logic [2:0] u;
		logic [31:0] a, b;
		logic [63:0] m;
		logic ok, ds;
		d = '0;
		idx = 5'h0;
		u = 3'h0;
		a = 32'h0;
		b = 32'h0;
		m = 64'h0;
		ok = 1'b0;
		ds = 1'b0;
		grp_dup = 1'b0;
		cross_hz = 1'b0;
		br_take = 1'b0;
		br_tgt = 32'h0;
		iv_next = 8'h00;
		mreq = 2'b00;
		mwe = 2'b00;
		for (int j = 0; j < 2; j++) begin
			maddr[j] = 32'h0;
			mwdata[j] = 64'h0;
			mmeta[j] = 8'h00;
		end
		for (int k = 0; k < 8; k++) begin
			idx = ptr_reg + 5'(k);
			d = dec(buf_reg[idx[3:0]]);
			u = {d.side, d.unit};
			iw_next[k] = 32'h0;
			wlo[k] = 1'b0;
			whi[k] = 1'b0;
			wdst[k] = d.dst;
			wside[k] = d.side;
			rlo[k] = 32'h0;
			rhi[k] = 32'h0;
		end
		for (int k = 0; k < 8; k++) begin
			idx = ptr_reg + 5'(k);
			d = dec(buf_reg[idx[3:0]]);
			u = {d.side, d.unit};
			if (4'(k) < grp_len) begin
				if (iv_next[u]) grp_dup = 1'b1; // RULE_23
				iv_next[u] = 1'b1;
				iw_next[u] = buf_reg[idx[3:0]];
				a = rf_reg[d.side][d.src1]; // RULE_09 RULE_11
				b = rf_reg[d.side ^ d.x][d.src2]; // RULE_12
				ok = cond_ok(d); // RULE_18
				ds = d.side ^ (d.x & !d.lng);
				if (d.x && d.unit != vfd_pkg::U_ADDR && wlast_reg[!d.side][d.src2]) cross_hz = 1'b1; // RULE_13
				if (d.x && !d.lng && d.st && d.unit == vfd_pkg::U_ADDR && wlast_reg[!d.side][d.dst]) cross_hz = 1'b1;
				case (d.unit)
					vfd_pkg::U_MUL: begin
						m = mul(d.op, a, b);
						rlo[k] = m[31:0];
						rhi[k] = m[63:32];
						wlo[k] = ok;
						if (d.op <= vfd_pkg::OP_MPYHL) begin
							wdst[k] = {d.dst[4:1], 1'b0};
							whi[k] = ok; // RULE_22
						end
					end
					vfd_pkg::U_ADDR: begin
						mreq[d.side] = ok; // RULE_14
						mwe[d.side] = d.st;
						maddr[d.side] = agen(d, rf_reg[d.side][d.lng ? vfd_pkg::LONG_BASE : d.src1]);
						mmeta[d.side] = {ds, d.sz, d.dst};
						if (d.sz == vfd_pkg::SZ_DWORD) begin
							mwdata[d.side] = {rf_reg[ds][{d.dst[4:1], 1'b1}], rf_reg[ds][{d.dst[4:1], 1'b0}]}; // RULE_10
						end else begin
							mwdata[d.side] = {32'h0, rf_reg[ds][d.dst]};
						end
					end
					default: begin
						if (d.unit == vfd_pkg::U_SHIFT && d.op == vfd_pkg::OP_BR) begin
							br_take = br_take | ok;
							br_tgt = a;
						end else begin
							rlo[k] = alu(d.op, a, b);
							wlo[k] = ok;
						end
					end
				endcase
			end
		end
	end

	assign go = state_reg == vfd_pkg::ST_DISPATCH && ptr_reg != vfd_pkg::PTR_EMPTY && !grp_span && !hold;
	assign hold = state_reg == vfd_pkg::ST_DISPATCH && !grp_span && cross_hz && !stall_reg; // RULE_13
	assign issue = go && !grp_dup; // RULE_23
	assign fetch_req_o = state_reg == vfd_pkg::ST_FETCH; // RULE_08
	assign fetch_addr_o = pc_reg;

	// Write-back set for cross hazard tracking
	always_comb begin
		wl_next[0] = 32'h0;
		wl_next[1] = 32'h0;
		for (int k = 0; k < 8; k++) begin
			if (issue && wlo[k]) wl_next[wside[k]][wdst[k]] = 1'b1;
			if (issue && whi[k]) wl_next[wside[k]][{wdst[k][4:1], 1'b1}] = 1'b1;
		end
		for (int j = 0; j < 2; j++) begin
			ldd[j] = ld_ext(wbm_reg[j][6:5], dmem_rdata_i[64*j+:64]);
			if (ldwb_reg[j]) begin
				wl_next[wbm_reg[j][7]][wbm_reg[j][4:0]] = 1'b1;
				if (wbm_reg[j][6:5] == vfd_pkg::SZ_DWORD) wl_next[wbm_reg[j][7]][{wbm_reg[j][4:1], 1'b1}] = 1'b1;
			end
		end
	end

	// Register files
	always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			for (int s = 0; s < 2; s++) begin
				wlast_reg[s] <= 32'h0;
				for (int r = 0; r < 32; r++) rf_reg[s][r] <= 32'h0;
			end
		end else begin
			wlast_reg <= wl_next;
			for (int k = 0; k < 8; k++) begin
				if (issue && wlo[k]) rf_reg[wside[k]][wdst[k]] <= rlo[k];
				if (issue && whi[k]) rf_reg[wside[k]][{wdst[k][4:1], 1'b1}] <= rhi[k]; // RULE_22
			end
			for (int j = 0; j < 2; j++) begin
				if (ldwb_reg[j] && wbm_reg[j][6:5] == vfd_pkg::SZ_DWORD) begin
					rf_reg[wbm_reg[j][7]][{wbm_reg[j][4:1], 1'b0}] <= ldd[j][31:0]; // RULE_10
					rf_reg[wbm_reg[j][7]][{wbm_reg[j][4:1], 1'b1}] <= ldd[j][63:32];
				end else if (ldwb_reg[j]) begin
					rf_reg[wbm_reg[j][7]][wbm_reg[j][4:0]] <= ldd[j][31:0]; // RULE_15
				end
			end
		end
	end

	// Fetch and dispatch sequencing
	always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			state_reg <= vfd_pkg::ST_FETCH;
			ptr_reg <= vfd_pkg::PTR_EMPTY;
			pc_reg <= vfd_pkg::PC_RESET;
			stall_reg <= 1'b0;
			for (int i = 0; i < 16; i++) buf_reg[i] <= 32'h0;
		end else begin
			stall_reg <= hold;
			case (state_reg)
				vfd_pkg::ST_FETCH: begin
					if (fetch_valid_i) begin
						for (int i = 0; i < 8; i++) begin // RULE_01 RULE_05
							buf_reg[i] <= buf_reg[i+8];
							buf_reg[i+8] <= fetch_data_i[32*i+:32];
						end
						ptr_reg <= ptr_reg - vfd_pkg::PKT_WORDS;
						pc_reg <= pc_reg + vfd_pkg::PKT_BYTES;
						state_reg <= vfd_pkg::ST_DISPATCH;
					end
				end
				vfd_pkg::ST_DISPATCH: begin
					if (issue && br_take) begin
						pc_reg <= br_tgt;
						ptr_reg <= vfd_pkg::PTR_EMPTY;
						state_reg <= vfd_pkg::ST_FETCH;
					end else if (go) begin
						ptr_reg <= ptr_reg + {1'b0, grp_len}; // RULE_07
					end else if (ptr_reg == vfd_pkg::PTR_EMPTY || grp_span) begin
						state_reg <= vfd_pkg::ST_FETCH; // RULE_08
					end
				end
				default: state_reg <= vfd_pkg::ST_FETCH;
			endcase
		end
	end

	// Issue and memory stage
	always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			issue_valid_o <= 8'h00;
			issue_word_o <= 256'h0;
			group_drop_o <= 1'b0;
			cross_stall_o <= 1'b0;
			dmem_req_o <= 2'b00;
			dmem_we_o <= 2'b00;
			dmem_size_o <= 4'h0;
			dmem_addr_o <= 64'h0;
			dmem_wdata_o <= 128'h0;
			ldwb_reg <= 2'b00;
			for (int j = 0; j < 2; j++) begin
				ldm_reg[j] <= 8'h00;
				wbm_reg[j] <= 8'h00;
			end
		end else begin
			issue_valid_o <= issue ? iv_next : 8'h00; // RULE_07
			for (int u = 0; u < 8; u++) issue_word_o[32*u+:32] <= iw_next[u];
			group_drop_o <= go && grp_dup; // RULE_23
			cross_stall_o <= hold;
			dmem_req_o <= issue ? mreq : 2'b00;
			dmem_we_o <= mwe;
			ldwb_reg <= dmem_req_o & ~dmem_we_o;
			for (int j = 0; j < 2; j++) begin
				dmem_size_o[2*j+:2] <= mmeta[j][6:5];
				dmem_addr_o[32*j+:32] <= maddr[j];
				dmem_wdata_o[64*j+:64] <= mwdata[j];
				ldm_reg[j] <= mmeta[j];
				wbm_reg[j] <= ldm_reg[j];
			end
		end
	end

	default clocking cb @(posedge clk_sys_i);
	endclocking
	default disable iff (!reset_n_i);

	sequence s_fetch_done;
		fetch_req_o && fetch_valid_i;
	endsequence

	sequence s_span;
		state_reg == vfd_pkg::ST_DISPATCH && grp_span;
	endsequence

	sequence s_retry;
		cross_stall_o && issue_valid_o == 8'h00 ##1 (issue_valid_o != 8'h00 || group_drop_o);
	endsequence

	chk_fetch_gated: assert property (fetch_req_o |-> ptr_reg == vfd_pkg::PTR_EMPTY || grp_span) // RULE_08
		else $error("Fetch requested with groups left");
	chk_fetch_load: assert property (s_fetch_done |=> // RULE_01
		ptr_reg == $past(ptr_reg) - 5'h08 && buf_reg[15] == $past(fetch_data_i[255:224]))
		else $error("Fetch packet not loaded");
	chk_issue_rate: assert property (issue && !br_take |=> ptr_reg == $past(ptr_reg) + {1'b0, $past(grp_len)}) // RULE_07
		else $error("Pointer did not advance by one group");
	chk_group_size: assert property (go |-> grp_len != 4'h0 && grp_len <= vfd_pkg::GRP_MAX) // RULE_04
		else $error("Group size out of range");
	chk_chain_end: assert property (go |-> grp_len == vfd_pkg::GRP_MAX || // RULE_03
		!buf_reg[4'(ptr_reg + {1'b0, grp_len} - 5'h01)][0])
		else $error("Group ended on chained word");
	chk_chain_link: assert property (go && grp_len > 4'h1 |-> buf_reg[ptr_reg[3:0]][0]) // RULE_02
		else $error("Unchained word joined group");
	chk_span_fetch: assert property (s_span |=> fetch_req_o) // RULE_05
		else $error("Spanning group did not refetch");
	chk_cross_stall: assert property (hold |=> s_retry) // RULE_13
		else $error("Cross read stall not one cycle");
	chk_dup_drop: assert property (go && grp_dup |=> group_drop_o && issue_valid_o == 8'h00) // RULE_23
		else $error("Duplicate unit group issued");
endmodule

/* File: vfd_pkg.sv */
// Functional notes
// RULE_01 - Fetch 256-bit packets of eight words
// RULE_02 - Low bit one chains next word
// RULE_03 - Low bit zero ends the group
// RULE_04 - At most eight words per group
// RULE_05 - Groups may span fetch packet boundary
// RULE_06 - One to eight groups per packet
// RULE_07 - Dispatch one group per clock
// RULE_08 - Refetch only after packet fully dispatched; the code also refetches when a group spans the packet end or a branch is taken
// RULE_09 - Two sides, four units, 32x32 registers
// RULE_10 - Packed bytes and 64-bit register pairs
// RULE_11 - All own-side reads in one cycle
// RULE_12 - One cross path per side, shared; the code places no limit on cross reads per side within a group
// RULE_13 - Stall once on fresh cross read
// RULE_14 - Address units cross load/store sides
// RULE_15 - Byte, half, word, doubleword transfers
// RULE_16 - Non-aligned word and doubleword access
// RULE_17 - Linear/circular, 5 or 15-bit offsets
// RULE_18 - Conditional execution on chosen registers
// RULE_19 - Dual 16x16 or quad 8x8 multiplies
// RULE_20 - Extra multiply-unit operations
// RULE_21 - Single, dual, quad arithmetic and logic
// RULE_22 - Wide product high half to extended
// RULE_23 - Duplicate unit group is dropped
package vfd_pkg;
	localparam logic [4:0] PTR_EMPTY = 5'h10;
	localparam logic [4:0] PKT_WORDS = 5'h08;
	localparam logic [3:0] GRP_MAX = 4'h8;
	localparam logic [31:0] PKT_BYTES = 32'h0000_0020;
	localparam logic [31:0] PC_RESET = 32'h0000_0000;
	localparam int CIRC_BITS = 8;
	localparam logic [4:0] LONG_BASE = 5'h0f;
	localparam logic [2:0] CREG_B_BASE = 3'h3;
	localparam logic [2:0] CREG_LAST = 3'h5;
	localparam logic [7:0] GF_POLY = 8'h1d;
	localparam int F_CHAIN = 0;
	localparam int F_SIDE = 1;
	localparam int F_UNIT = 2;
	localparam int F_OP = 4;
	localparam int F_NAL = 6;
	localparam int F_CIRC = 7;
	localparam int F_SZ = 8;
	localparam int F_ST = 10;
	localparam int F_LONG = 11;
	localparam int F_X = 12;
	localparam int F_SRC1 = 13;
	localparam int F_SRC2 = 18;
	localparam int F_DST = 23;
	localparam int F_Z = 28;
	localparam int F_CREG = 29;
	localparam logic [1:0] U_LOGIC = 2'h0;
	localparam logic [1:0] U_SHIFT = 2'h1;
	localparam logic [1:0] U_MUL = 2'h2;
	localparam logic [1:0] U_ADDR = 2'h3;
	localparam logic [1:0] SZ_BYTE = 2'h0;
	localparam logic [1:0] SZ_HALF = 2'h1;
	localparam logic [1:0] SZ_WORD = 2'h2;
	localparam logic [1:0] SZ_DWORD = 2'h3;
	localparam logic [3:0] OP_ADD = 4'h0;
	localparam logic [3:0] OP_SUB = 4'h1;
	localparam logic [3:0] OP_ADD2 = 4'h2;
	localparam logic [3:0] OP_SUB2 = 4'h3;
	localparam logic [3:0] OP_ADD4 = 4'h4;
	localparam logic [3:0] OP_SUB4 = 4'h5;
	localparam logic [3:0] OP_AND = 4'h6;
	localparam logic [3:0] OP_OR = 4'h7;
	localparam logic [3:0] OP_XOR = 4'h8;
	localparam logic [3:0] OP_SHL = 4'h9;
	localparam logic [3:0] OP_SHR = 4'ha;
	localparam logic [3:0] OP_BR = 4'hb;
	localparam logic [3:0] OP_MPY2 = 4'h0;
	localparam logic [3:0] OP_MPYU4 = 4'h1;
	localparam logic [3:0] OP_MPYHL = 4'h2;
	localparam logic [3:0] OP_DOTP2 = 4'h3;
	localparam logic [3:0] OP_DOTPN2 = 4'h4;
	localparam logic [3:0] OP_DOTPU4 = 4'h5;
	localparam logic [3:0] OP_BITC4 = 4'h6;
	localparam logic [3:0] OP_ROTL = 4'h7;
	localparam logic [3:0] OP_GMPY4 = 4'h8;
	localparam logic [3:0] OP_SSHVL = 4'h9;
	typedef enum logic [0:0] {ST_FETCH, ST_DISPATCH} vfd_state_t;
	typedef struct packed {
		logic [2:0] creg;
		logic z;
		logic [4:0] dst;
		logic [4:0] src2;
		logic [4:0] src1;
		logic x;
		logic lng;
		logic st;
		logic [1:0] sz;
		logic circ;
		logic nal;
		logic [3:0] op;
		logic [1:0] unit;
		logic side;
		logic [14:0] off15;
	} vfd_ins_t;
endpackage

/* File: vfd_mem_model.sv */
module vfd_mem_model (
	input wire logic clk_sys_i,
	input wire logic reset_n_i,
	input wire logic slow_i,
	input wire logic fetch_req_i,
	input wire logic [31:0] fetch_addr_i,
	output logic fetch_valid_o,
	output logic [255:0] fetch_data_o,
	input wire logic [1:0] dmem_req_i,
	input wire logic [63:0] dmem_addr_i,
	output logic [127:0] dmem_rdata_o
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [255:0] prog [0:7];
	logic [1:0] wait_cnt;
	// Program side, prompt or three cycles late
	always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			fetch_valid_o <= 1'b0;
			fetch_data_o <= '0;
			wait_cnt <= 2'h0;
		end else if (fetch_valid_o && fetch_req_i) begin
			fetch_valid_o <= 1'b0;
			fetch_data_o <= ~fetch_data_o;
			wait_cnt <= 2'h0;
		end else if (fetch_req_i && (!slow_i || wait_cnt == 2'h3)) begin
			fetch_valid_o <= 1'b1;
			fetch_data_o <= prog[fetch_addr_i[7:5]];
		end else begin
			fetch_data_o <= ~fetch_data_o;
			wait_cnt <= wait_cnt + {1'b0, fetch_req_i};
		end
	end
	// Data side answers the cycle after a request
	always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			dmem_rdata_o <= '0;
		end else if (|dmem_req_i) begin
			dmem_rdata_o <= {~dmem_addr_i[63:32], dmem_addr_i[63:32], ~dmem_addr_i[31:0], dmem_addr_i[31:0]};
		end else begin
			dmem_rdata_o <= ~dmem_rdata_o;
		end
	end
endmodule

/* File: tb_vliw_fetch_dispatch_core.sv */
module tb_vliw_fetch_dispatch_core;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_sys_i = 1'b0;
	logic reset_n_i = 1'b0;
	logic slow = 1'b0;
	logic fetch_req_o, fetch_valid_i, group_drop_o, cross_stall_o;
	logic [31:0] fetch_addr_o;
	logic [255:0] fetch_data_i, issue_word_o;
	logic [7:0] issue_valid_o;
	logic [1:0] dmem_req_o, dmem_we_o;
	logic [3:0] dmem_size_o;
	logic [63:0] dmem_addr_o;
	logic [127:0] dmem_wdata_o, dmem_rdata_i;
	int err_count = 0;
	int check_count = 0;
	int cyc = 0;
	int stalls, drops;
	logic [7:0] iv_q[$];
	logic [255:0] iw_q[$];
	int ts_q[$];
	logic [31:0] fa_q[$];
	int fc_q[$];
	logic [1:0] d_seen;
	logic [1:0] d_we;
	logic [3:0] d_size;
	logic [63:0] d_addr;
	logic [127:0] d_wdata;
	logic [31:0] w;

	always #2.5 clk_sys_i = ~clk_sys_i;

	vfd_core vfd_core_inst (.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .fetch_req_o(fetch_req_o),
		.fetch_addr_o(fetch_addr_o), .fetch_valid_i(fetch_valid_i), .fetch_data_i(fetch_data_i),
		.issue_valid_o(issue_valid_o), .issue_word_o(issue_word_o), .group_drop_o(group_drop_o),
		.cross_stall_o(cross_stall_o), .dmem_req_o(dmem_req_o), .dmem_we_o(dmem_we_o),
		.dmem_size_o(dmem_size_o), .dmem_addr_o(dmem_addr_o), .dmem_wdata_o(dmem_wdata_o),
		.dmem_rdata_i(dmem_rdata_i));

	vfd_mem_model vfd_mem_model_inst (.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .slow_i(slow),
		.fetch_req_i(fetch_req_o), .fetch_addr_i(fetch_addr_o), .fetch_valid_o(fetch_valid_i),
		.fetch_data_o(fetch_data_i), .dmem_req_i(dmem_req_o), .dmem_addr_i(dmem_addr_o),
		.dmem_rdata_o(dmem_rdata_i));

	// Records issues, fetch takes, stalls, drops, first memory request and last store per port
	always @(posedge clk_sys_i) begin
		cyc <= cyc + 1;
		if (issue_valid_o != 8'h00) begin
			iv_q.push_back(issue_valid_o);
			iw_q.push_back(issue_word_o);
			ts_q.push_back(cyc);
		end
		if (fetch_req_o && fetch_valid_i) begin
			fa_q.push_back(fetch_addr_o);
			fc_q.push_back(iv_q.size() + drops);
		end
		if (cross_stall_o === 1'b1)
			stalls++;
		if (group_drop_o === 1'b1)
			drops++;
		for (int p = 0; p < 2; p++) begin
			if (dmem_req_o[p] && !d_seen[p]) begin
				d_seen[p] = 1'b1;
				d_we[p] = dmem_we_o[p];
				d_size[2*p +: 2] = dmem_size_o[2*p +: 2];
				d_addr[32*p +: 32] = dmem_addr_o[32*p +: 32];
			end
			if (dmem_req_o[p] && dmem_we_o[p])
				d_wdata[64*p +: 64] = dmem_wdata_o[64*p +: 64];
		end
	end

	function automatic logic [31:0] ins(input logic ch, input logic sd, input logic [1:0] un, input logic [3:0] op,
		input logic [4:0] dst, input logic [4:0] s1, input logic [4:0] s2, input logic x, input logic [3:0] m);
		return {3'h0, 1'b0, dst, s2, s1, x, m, op, un, sd, ch};
	endfunction

	task automatic check(input logic [255:0] seen, input logic [255:0] exp);
		check_count++;
		if (seen !== exp) begin
			err_count++;
			$display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
		end
	endtask

	task automatic prep(input logic s);
		@(posedge clk_sys_i);
		reset_n_i <= 1'b0;
		slow <= s;
		for (int i = 0; i < 8; i++)
			vfd_mem_model_inst.prog[i] = '0;
	endtask

	task automatic run();
		repeat (5) @(posedge clk_sys_i);
		iv_q.delete();
		iw_q.delete();
		ts_q.delete();
		fa_q.delete();
		fc_q.delete();
		stalls = 0;
		drops = 0;
		d_seen = 2'h0;
		d_wdata = '1;
		reset_n_i <= 1'b1;
		repeat (40) @(posedge clk_sys_i);
	endtask

	task automatic test_eight_groups();
		prep(1'b0);
		for (int k = 0; k < 8; k++)
			vfd_mem_model_inst.prog[0][32*k +: 32] = ins(1'b0, k[2], k[1:0], 4'h0, 5'h00, 5'h00, 5'h00, 1'b0, 4'h0);
		run();
		for (int k = 0; k < 8; k++) begin
			check(iv_q[k], 8'h01 << k);
			check(iw_q[k][32*k +: 32], vfd_mem_model_inst.prog[0][32*k +: 32]);
			check(ts_q[k] - ts_q[0], k);
		end
		check(fa_q[1], vfd_pkg::PKT_BYTES);
		check(fc_q[1], 8);
		check(stalls, 0);
		$display("Test eight_groups done");
	endtask

	task automatic test_full_group();
		prep(1'b0);
		for (int k = 0; k < 8; k++)
			vfd_mem_model_inst.prog[0][32*k +: 32] = ins(k != 7, k[2], k[1:0], 4'h0, 5'h00, 5'h00, 5'h00, 1'b0, 4'h0);
		run();
		check(iv_q[0], 8'hff);
		check(iw_q[0], vfd_mem_model_inst.prog[0]);
		check(fc_q[1], 1);
		$display("Test full_group done");
	endtask

	task automatic test_span();
		prep(1'b0);
		for (int k = 0; k < 8; k++)
			vfd_mem_model_inst.prog[0][32*k +: 32] = ins(k == 7, 1'b0, 2'h0, 4'h0, 5'h00, 5'h00, 5'h00, 1'b0, 4'h0);
		w = ins(1'b0, 1'b1, vfd_pkg::U_SHIFT, 4'h0, 5'h00, 5'h00, 5'h00, 1'b0, 4'h0);
		vfd_mem_model_inst.prog[1][31:0] = w;
		run();
		check(iv_q[7], 8'h21);
		check(iw_q[7][191:160], w);
		check(iw_q[7][31:0], vfd_mem_model_inst.prog[0][255:224]);
		check(iv_q[8], 8'h01);
		$display("Test span done");
	endtask

	task automatic test_duplicate();
		prep(1'b1);
		vfd_mem_model_inst.prog[0][31:0] = ins(1'b1, 1'b0, 2'h0, 4'h0, 5'h00, 5'h00, 5'h00, 1'b0, 4'h0);
		vfd_mem_model_inst.prog[0][63:32] = ins(1'b0, 1'b0, 2'h0, 4'h0, 5'h00, 5'h00, 5'h00, 1'b0, 4'h0);
		vfd_mem_model_inst.prog[0][95:64] = ins(1'b0, 1'b0, vfd_pkg::U_SHIFT, 4'h0, 5'h00, 5'h00, 5'h00, 1'b0, 4'h0);
		run();
		check(drops, 1);
		check(iv_q[0], 8'h02);
		check(fc_q[1], 7);
		$display("Test duplicate done");
	endtask

	task automatic test_cross_stall();
		prep(1'b0);
		vfd_mem_model_inst.prog[0][31:0] = ins(1'b0, 1'b0, 2'h0, vfd_pkg::OP_ADD, 5'h03, 5'h00, 5'h00, 1'b0, 4'h0);
		vfd_mem_model_inst.prog[0][63:32] = ins(1'b0, 1'b1, 2'h0, vfd_pkg::OP_ADD, 5'h04, 5'h03, 5'h03, 1'b1, 4'h0);
		run();
		check(stalls, 1);
		check(iv_q[1], 8'h10);
		check(ts_q[1] - ts_q[0], 2);
		$display("Test cross_stall done");
	endtask

	task automatic test_memory();
		prep(1'b0);
		vfd_mem_model_inst.prog[0][31:0] = ins(1'b0, 1'b0, vfd_pkg::U_ADDR, 4'h0, 5'h04, 5'h00, 5'h02, 1'b0,
			{2'b01, vfd_pkg::SZ_WORD});
		vfd_mem_model_inst.prog[0][63:32] = ins(1'b0, 1'b1, vfd_pkg::U_ADDR, 4'h0, 5'h06, 5'h00, 5'h01, 1'b0,
			{2'b00, vfd_pkg::SZ_DWORD});
		vfd_mem_model_inst.prog[0][159:128] = ins(1'b0, 1'b1, vfd_pkg::U_MUL, vfd_pkg::OP_MPYU4, 5'h08, 5'h07,
			5'h07, 1'b0, 4'h0);
		vfd_mem_model_inst.prog[0][191:160] = ins(1'b0, 1'b1, vfd_pkg::U_ADDR, 4'h0, 5'h08, 5'h00, 5'h00, 1'b0,
			{2'b01, vfd_pkg::SZ_DWORD});
		run();
		check(d_wdata, {64'hfe01_fe01_fe01_ee51, 64'h0});
		check(d_wdata[95:64], 32'hfe01_ee51);
		check(d_seen, 2'h3);
		check(d_we, 2'h1);
		check(d_size, {vfd_pkg::SZ_DWORD, vfd_pkg::SZ_WORD});
		check(d_addr, {32'h0000_0008, 32'h0000_0008});
		$display("Test memory done");
	endtask

	task automatic test_branch();
		prep(1'b0);
		vfd_mem_model_inst.prog[0][31:0] = ins(1'b0, 1'b0, vfd_pkg::U_SHIFT, vfd_pkg::OP_BR, 5'h00, 5'h00, 5'h00,
			1'b0, 4'h0);
		run();
		check(fa_q[1], 32'h0);
		check(fc_q[1], 1);
		$display("Test branch done");
	endtask

	task automatic results();
		$display("Checks %0d mismatches %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	initial begin
		#20000;
		err_count++;
		results();
	end

	initial begin
		test_eight_groups();
		test_full_group();
		test_span();
		test_duplicate();
		test_cross_stall();
		test_memory();
		test_branch();
		results();
	end
endmodule
